// ---- pmrc_pkg.sv ----
// constants and types shared by the power mode and reset control files
// What this block does
// - setting the idle request bit enters idle mode
// - idle mode stops the processor core clock
// - idle mode keeps peripheral and interrupt clocks running
// - any interrupt or a reset ends idle mode
// - setting the power-down request bit enters power-down mode
// - power-down stops every clock and the oscillator
// - only reset or an enabled wake interrupt two to nine ends power-down
// - strobe off bit suppresses the address latch strobe during internal execution
// - external code or data access still drives the strobe
// - strobe stops again once external access or external execution ends
// - the reset pin is sampled at state five phase two of each machine cycle
// - short glitches on the reset pin do not cause a reset
// - reset loads port latches with ff and stack pointer with 07
// - reset clears power control to 00 except bit 4, which is kept
// - reset clears other registers to 00 except the serial buffer
// - in idle the watchdog runs only when its idle-run bit is set
package pmrc_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_STACK_PTR  = 8'h81;
  localparam logic [7:0] IDX_POWER_CTRL = 8'h87;
  localparam logic [7:0] IDX_AUX_CTRL   = 8'h8e;
  localparam logic [7:0] IDX_WDT_CTRL   = 8'h8f;
  localparam logic [7:0] IDX_PORT_LATCH = 8'h90;
  localparam logic [7:0] IDX_SER_BUF    = 8'h99;
  localparam logic [7:0] IDX_STATUS     = 8'ha0;
  localparam logic [7:0] IDX_WAKE_EN    = 8'he8;

  // field positions
  localparam int IDLE_BIT      = 0;
  localparam int PDOWN_BIT     = 1;
  localparam int KEEP_BIT      = 4;
  localparam int STROBE_OFF    = 0;
  localparam int WDT_EN_BIT    = 7;
  localparam int WDT_CLR_BIT   = 6;
  localparam int WDT_IDLE_BIT  = 5;

  // values after reset
  localparam logic [7:0] REG_RESET_VAL  = 8'h00;
  localparam logic [7:0] PORT_RESET_VAL = 8'hff;
  localparam logic [7:0] SP_RESET_VAL   = 8'h07;
  localparam logic [7:0] PWR_KEEP_MASK  = 8'h10;

  // machine cycle timing: 6 states of 2 phases, one phase per clock
  localparam logic [3:0] MC_LAST_PHASE = 4'hb;
  localparam logic [3:0] SAMPLE_PHASE  = 4'h9;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE, MODE_PDOWN} pmrc_mode_e;

  function automatic logic pmrc_hit(input logic [11:0] addr, input logic [7:0] idx);
    return addr[11:2] == {2'h0, idx};
  endfunction

endpackage

// ---- pmrc_rst_if.sv ----
// signals between the core logic and the reset pin filter
`timescale 1ns/1ps
interface pmrc_rst_if;
  logic sample_stb;
  logic rst_pin;
  logic chip_reset;
  modport filt (input sample_stb, input rst_pin, output chip_reset);
  modport core (output sample_stb, output rst_pin, input chip_reset);
endinterface

// ---- pmrc_rst_filter.sv ----
// reset pin sampler and deglitch filter
`timescale 1ns/1ps
module pmrc_rst_filter (
  input  wire logic pclk,        // clock
  input  wire logic presetn,     // async reset, low
  pmrc_rst_if.filt  rif          // sample strobe, pin, filtered reset
);
  import pmrc_pkg::*;

  logic       last_reg;
  logic       chip_reset_reg;

  // two matching samples one machine cycle apart change the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg       <= 1'b0;
      chip_reset_reg <= 1'b0;
    end else if (rif.sample_stb) begin
      last_reg <= rif.rst_pin;
      if (rif.rst_pin && last_reg) begin
        chip_reset_reg <= 1'b1;
      end else if (!rif.rst_pin && !last_reg) begin
        chip_reset_reg <= 1'b0;
      end
    end
  end

  assign rif.chip_reset = chip_reset_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_RST_RISE: assert property ($rose(rif.chip_reset) |->
    $past(rif.sample_stb) && $past(rif.rst_pin) && $past(last_reg))
    else $error("reset rose without two high samples");
  AST_RST_GLITCH: assert property (
    (rif.sample_stb && rif.rst_pin && !last_reg && !rif.chip_reset) |=> !rif.chip_reset)
    else $error("single high sample caused a reset");
  AST_RST_HOLD: assert property (!rif.sample_stb |=> $stable(rif.chip_reset))
    else $error("reset level changed outside the sample point");
endmodule

// ---- pmrc_strobe.sv ----
// address latch strobe gating for emission reduction
`timescale 1ns/1ps
module pmrc_strobe (
  input  wire logic pclk,        // clock
  input  wire logic presetn,     // async reset, low
  input  wire logic strobe_off,  // suppress strobe during internal execution
  input  wire logic ale_req,     // raw strobe from the bus sequencer
  input  wire logic ext_access,  // external code or data access in progress
  input  wire logic ext_exec,    // program counter outside internal memory
  output logic      ale_out      // strobe to the pin
);
  import pmrc_pkg::*;

  logic ale_reg;
  logic ale_next;

  always_comb begin
    if (strobe_off) begin
      ale_next = ale_req && (ext_access || ext_exec);
    end else begin
      ale_next = ale_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ale_reg <= 1'b0;
    end else begin
      ale_reg <= ale_next;
    end
  end

  assign ale_out = ale_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ALE_OFF: assert property ((strobe_off && !ext_access && !ext_exec) |=> !ale_out)
    else $error("strobe toggled during internal execution");
  AST_ALE_EXT: assert property ((ale_req && (ext_access || ext_exec)) |=> ale_out)
    else $error("strobe missing on external access");
  AST_ALE_STOP: assert property (
    (strobe_off && $fell(ext_access || ext_exec)) |=> !ale_out)
    else $error("strobe still running after external access ended");
endmodule

// ---- pmrc_top.sv ----
// power mode, reset and strobe control with apb register access
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module pmrc_top (
  input  wire logic        pclk,          // 50 mhz clock
  input  wire logic        presetn,       // async reset, low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb enable
  input  wire logic        pwrite,        // apb write
  input  wire logic [11:0] paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  input  wire logic [3:0]  pstrb,         // apb byte strobes
  output logic [31:0]      prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped
  input  wire logic        rst_pin,       // external reset pin, high
  input  wire logic        irq_pending,   // any interrupt request
  input  wire logic [7:0]  wake_int,      // wake interrupts two to nine
  input  wire logic        ale_req,       // raw strobe from bus sequencer
  input  wire logic        ext_access,    // external memory access active
  input  wire logic        ext_exec,      // executing external code
  output logic             core_clk_en,   // core clock gate
  output logic             periph_clk_en, // peripheral clock gate
  output logic             osc_en,        // oscillator enable
  output logic             wdt_clk_en,    // watchdog clock gate
  output logic             ale_out,       // address latch strobe pin
  output logic             chip_reset,    // filtered internal reset
  output logic [7:0]       port_latch,    // port latch value
  output logic [7:0]       stack_ptr      // stack pointer value
);
  import pmrc_pkg::*;

  // ==========================================================
  // machine cycle phase counter and reset filter
  logic [3:0] ph_reg;
  pmrc_rst_if rif ();

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= 4'h0;
    end else if (ph_reg == MC_LAST_PHASE) begin
      ph_reg <= 4'h0;
    end else begin
      ph_reg <= ph_reg + 4'h1;
    end
  end

  assign rif.sample_stb = (ph_reg == SAMPLE_PHASE);
  assign rif.rst_pin    = rst_pin;
  assign chip_reset     = rif.chip_reset;

  pmrc_rst_filter u_filt (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif.filt)
  );

  // ==========================================================
  // apb decode
  logic       setup;
  logic       wr_en;
  logic       wr_lane;
  logic       mapped;
  logic [7:0] wdat;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign wr_lane = wr_en && pstrb[0];
  assign wdat    = pwdata[7:0];
  assign mapped  = pmrc_hit(paddr, IDX_STACK_PTR) || pmrc_hit(paddr, IDX_POWER_CTRL)
                || pmrc_hit(paddr, IDX_AUX_CTRL) || pmrc_hit(paddr, IDX_WDT_CTRL)
                || pmrc_hit(paddr, IDX_PORT_LATCH) || pmrc_hit(paddr, IDX_SER_BUF)
                || pmrc_hit(paddr, IDX_STATUS) || pmrc_hit(paddr, IDX_WAKE_EN);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  logic wr_power_control_reg;
  logic wr_aux;
  logic wr_wdt;
  logic wr_wake;
  logic wr_port;
  logic wr_sp;
  logic wr_rxtx;

  assign wr_power_control_reg = wr_lane && pmrc_hit(paddr, IDX_POWER_CTRL);
  assign wr_aux  = wr_lane && pmrc_hit(paddr, IDX_AUX_CTRL);
  assign wr_wdt  = wr_lane && pmrc_hit(paddr, IDX_WDT_CTRL);
  assign wr_wake = wr_lane && pmrc_hit(paddr, IDX_WAKE_EN);
  assign wr_port = wr_lane && pmrc_hit(paddr, IDX_PORT_LATCH);
  assign wr_sp   = wr_lane && pmrc_hit(paddr, IDX_STACK_PTR);
  assign wr_rxtx = wr_lane && pmrc_hit(paddr, IDX_SER_BUF);

  // ==========================================================
  // power mode state
  pmrc_mode_e mode_reg;
  pmrc_mode_e mode_next;
  logic [7:0] power_control_reg;
  logic       wake_hit;
  logic       mode_exit;
  logic [7:0] wake_en_reg;

  assign wake_hit = |(wake_int & wake_en_reg);

  always_comb begin
    mode_next = mode_reg;
    mode_exit = 1'b0;
    case (mode_reg)
      MODE_NORMAL: begin
        if (power_control_reg[PDOWN_BIT]) begin
          mode_next = MODE_PDOWN;
        end else if (power_control_reg[IDLE_BIT]) begin
          mode_next = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_pending || chip_reset) begin
          mode_next = MODE_NORMAL;
          mode_exit = 1'b1;
        end
      end
      MODE_PDOWN: begin
        if (wake_hit || chip_reset) begin
          mode_next = MODE_NORMAL;
          mode_exit = 1'b1;
        end
      end
      default: begin
        mode_next = MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================
  // power control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= REG_RESET_VAL;
    end else if (chip_reset) begin
      power_control_reg <= power_control_reg & PWR_KEEP_MASK;
    end else if (wr_power_control_reg) begin
      power_control_reg <= wdat;
    end else if (mode_exit) begin
      power_control_reg[IDLE_BIT]  <= 1'b0;
      power_control_reg[PDOWN_BIT] <= 1'b0;
    end
  end

  // ==========================================================
  // other registers, set to their reset values by the filtered reset except the serial buffer
  logic [7:0] aux_control;
  logic [7:0] wdt_ctrl_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_control <= REG_RESET_VAL;
    end else if (chip_reset) begin
      aux_control <= REG_RESET_VAL;
    end else if (wr_aux) begin
      aux_control <= wdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en_reg <= REG_RESET_VAL;
    end else if (chip_reset) begin
      wake_en_reg <= REG_RESET_VAL;
    end else if (wr_wake) begin
      wake_en_reg <= wdat;
    end
  end

  // the clear bit drops by itself one cycle after it is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_ctrl_reg <= REG_RESET_VAL;
    end else if (chip_reset) begin
      wdt_ctrl_reg <= REG_RESET_VAL;
    end else if (wr_wdt) begin
      wdt_ctrl_reg <= wdat;
    end else begin
      wdt_ctrl_reg[WDT_CLR_BIT] <= 1'b0;
    end
  end

  logic [7:0] port_latch_reg;
  logic [7:0] stack_ptr_reg;
  logic [7:0] serial_buffer_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_latch_reg <= PORT_RESET_VAL;
    end else if (chip_reset) begin
      port_latch_reg <= PORT_RESET_VAL;
    end else if (wr_port) begin
      port_latch_reg <= wdat;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr_reg <= SP_RESET_VAL;
    end else if (chip_reset) begin
      stack_ptr_reg <= SP_RESET_VAL;
    end else if (wr_sp) begin
      stack_ptr_reg <= wdat;
    end
  end

  // serial buffer keeps its content through every reset
  always_ff @(posedge pclk) begin
    if (wr_rxtx) begin
      serial_buffer_reg <= wdat;
    end
  end

  assign port_latch = port_latch_reg;
  assign stack_ptr  = stack_ptr_reg;

  // ==========================================================
  // clock gates
  logic wdt_idle_run_bit;
  logic wdt_on;

  assign wdt_idle_run_bit = wdt_ctrl_reg[WDT_IDLE_BIT];
  assign wdt_on           = wdt_ctrl_reg[WDT_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en   <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en        <= 1'b1;
      wdt_clk_en    <= 1'b0;
    end else begin
      core_clk_en   <= (mode_next == MODE_NORMAL);
      periph_clk_en <= (mode_next != MODE_PDOWN);
      osc_en        <= (mode_next != MODE_PDOWN);
      case (mode_next)
        MODE_NORMAL: wdt_clk_en <= wdt_on;
        MODE_IDLE:   wdt_clk_en <= wdt_on && wdt_idle_run_bit;
        default:     wdt_clk_en <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // strobe gating
  pmrc_strobe u_strobe (
    .pclk       (pclk),
    .presetn    (presetn),
    .strobe_off (aux_control[STROBE_OFF]),
    .ale_req    (ale_req),
    .ext_access (ext_access),
    .ext_exec   (ext_exec),
    .ale_out    (ale_out)
  );

  // ==========================================================
  // read data, captured in the setup phase
  logic [7:0] rd_byte;
  logic [7:0] status_val;

  assign status_val = {5'h00, chip_reset, mode_reg};

  always_comb begin
    rd_byte = 8'h00;
    if (pmrc_hit(paddr, IDX_POWER_CTRL)) rd_byte = power_control_reg;
    if (pmrc_hit(paddr, IDX_AUX_CTRL))   rd_byte = aux_control;
    if (pmrc_hit(paddr, IDX_WDT_CTRL))   rd_byte = wdt_ctrl_reg;
    if (pmrc_hit(paddr, IDX_WAKE_EN))    rd_byte = wake_en_reg;
    if (pmrc_hit(paddr, IDX_PORT_LATCH)) rd_byte = port_latch_reg;
    if (pmrc_hit(paddr, IDX_STACK_PTR))  rd_byte = stack_ptr_reg;
    if (pmrc_hit(paddr, IDX_SER_BUF))    rd_byte = serial_buffer_reg;
    if (pmrc_hit(paddr, IDX_STATUS))     rd_byte = status_val;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_idle_req;
    mode_reg == MODE_NORMAL && power_control_reg[IDLE_BIT] && !power_control_reg[PDOWN_BIT];
  endsequence
  sequence s_idle_wake;
    mode_reg == MODE_IDLE && irq_pending && !wr_power_control_reg;
  endsequence
  sequence s_pdown_wake;
    mode_reg == MODE_PDOWN && wake_hit && !wr_power_control_reg && !chip_reset;
  endsequence

  AST_IDLE_ENTER: assert property (s_idle_req |=> mode_reg == MODE_IDLE)
    else $error("idle request did not enter idle");
  AST_IDLE_CLK: assert property (s_idle_req |=> !core_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  AST_IDLE_PERIPH: assert property (mode_reg == MODE_IDLE |-> periph_clk_en && osc_en)
    else $error("peripheral clock stopped in idle");
  AST_IDLE_EXIT: assert property (s_idle_wake |=>
    mode_reg == MODE_NORMAL && !power_control_reg[IDLE_BIT] ##0 core_clk_en)
    else $error("interrupt did not end idle");
  AST_PDOWN_ENTER: assert property ((mode_reg == MODE_NORMAL && power_control_reg[PDOWN_BIT])
    |=> mode_reg == MODE_PDOWN)
    else $error("power-down request ignored");
  AST_PDOWN_CLK: assert property (mode_reg == MODE_PDOWN |->
    !osc_en && !periph_clk_en && !core_clk_en && !wdt_clk_en)
    else $error("clock running in power-down");
  AST_PDOWN_STAY: assert property ((mode_reg == MODE_PDOWN && !wake_hit && !chip_reset)
    |=> mode_reg == MODE_PDOWN)
    else $error("power-down left without a wake source");
  AST_PDOWN_WAKE: assert property (s_pdown_wake |=> mode_reg == MODE_NORMAL
    && !power_control_reg[PDOWN_BIT])
    else $error("enabled wake did not end power-down");
  AST_RST_VALUES: assert property (chip_reset |=>
    port_latch == PORT_RESET_VAL && stack_ptr == SP_RESET_VAL && aux_control == 8'h00)
    else $error("reset values not loaded");
  AST_PWR_KEEP: assert property (chip_reset |=>
    power_control_reg[KEEP_BIT] == $past(power_control_reg[KEEP_BIT])
    && (power_control_reg & ~PWR_KEEP_MASK) == 8'h00)
    else $error("power control reset value wrong");
  AST_SERBUF_KEEP: assert property ((chip_reset && !wr_rxtx) |=> $stable(serial_buffer_reg))
    else $error("serial buffer changed on reset");
  AST_WDT_IDLE: assert property (mode_reg == MODE_IDLE |->
    wdt_clk_en == $past(wdt_on && wdt_idle_run_bit))
    else $error("watchdog idle gating wrong");
endmodule

// ---- pmrc_rst_src.sv ----
// model of the external reset circuit that drives the reset pin
`timescale 1ns/1ps
module pmrc_rst_src (
  input  wire logic       pclk,    // clock, kept running while the pin is held
  input  wire logic       go,      // start one pulse
  input  wire logic [7:0] len,     // pulse length in clocks
  output logic            rst_pin  // reset pin, active high
);
  logic [7:0] cnt_reg;

  initial cnt_reg = 8'h00;

  // pin held high for len clocks with the clock running; a long pulse spans two samples
  always @(posedge pclk) begin
    if (go) begin
      cnt_reg <= len;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // released pin falls to its pull-down level
  assign rst_pin = (cnt_reg != 8'h00);
endmodule

// ---- pmrc_top_tb.sv ----
// self-checking bench for the power mode, reset and strobe control block
`timescale 1ns/1ps
module pmrc_top_tb;
  import pmrc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_pin, rst_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  wake_int, rst_len, en, port_latch, stack_ptr;
  logic        irq_pending, ale_req, ext_access, ext_exec, ale_out, chip_reset;
  logic        core_clk_en, periph_clk_en, osc_en, wdt_clk_en, prev_ale, seen;
  logic [2:0]  r;
  logic [32:0] exp_q[$];
  int          fails, cmp_count, n;

  pmrc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_pin(rst_pin), .irq_pending(irq_pending),
    .wake_int(wake_int), .ale_req(ale_req), .ext_access(ext_access), .ext_exec(ext_exec),
    .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .wdt_clk_en(wdt_clk_en), .ale_out(ale_out), .chip_reset(chip_reset),
    .port_latch(port_latch), .stack_ptr(stack_ptr));

  pmrc_rst_src rst_src (.pclk(pclk), .go(rst_go), .len(rst_len), .rst_pin(rst_pin));

  always #10 pclk = ~pclk;

  // ==========================================================
  // checking and closing
  task automatic check(input string what, input logic [32:0] seen_v, input logic [32:0] exp);
    cmp_count++;
    if (seen_v !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask

  task automatic close_out();
    if (exp_q.size() != 0) begin
      fails++;
    end
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // read results are matched against the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // ==========================================================
  // bus and pin drivers
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] v, input logic err);
    exp_q.push_back({err, 24'h0, v});
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pulse(input logic [7:0] len);
    @(posedge pclk);
    rst_go <= 1'b1;
    rst_len <= len;
    @(posedge pclk);
    rst_go <= 1'b0;
  endtask

  task automatic wait_rst(input logic v);
    n = 0;
    while (chip_reset !== v && n < 80) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 80) begin
      fails++;
      $display("[FAIL] chip_reset expected %h seen %h", v, chip_reset);
      close_out();
    end
  endtask

  task automatic strobe_run(input logic aux);
    apb(1'b1, IDX_AUX_CTRL, {7'h0, aux});
    prev_ale = 1'b0;
    for (int i = 0; i < 16; i++) begin
      r = 3'($urandom);
      @(posedge pclk);
      ale_req <= r[0];
      ext_access <= r[1] & r[2];
      ext_exec <= r[2] & ~r[1];
      @(negedge pclk);
      check("ale_out", ale_out, prev_ale);
      prev_ale = r[0] & (~aux | r[2]);
    end
    @(posedge pclk);
    ale_req <= 1'b0;
    ext_access <= 1'b0;
    ext_exec <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, rst_go, irq_pending, ale_req, ext_access, ext_exec} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    wake_int = 8'h00;
    rst_len = 8'h00;
    void'($urandom(32'h13ea4a0e));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("port", port_latch, PORT_RESET_VAL);
    check("sp", stack_ptr, SP_RESET_VAL);
    rd(IDX_STACK_PTR, SP_RESET_VAL, 1'b0);
    rd(IDX_PORT_LATCH, PORT_RESET_VAL, 1'b0);
    rd(IDX_POWER_CTRL, 8'h00, 1'b0);
    rd(IDX_AUX_CTRL, 8'h00, 1'b0);
    rd(IDX_WAKE_EN, 8'h00, 1'b0);
    rd(8'h55, 8'h00, 1'b1);
    strobe_run(1'b0);
    strobe_run(1'b1);
    // idle entry and exit
    apb(1'b1, IDX_WDT_CTRL, 8'h80);
    apb(1'b1, IDX_POWER_CTRL, 8'h01);
    settle(2);
    check("idle", {core_clk_en, periph_clk_en, osc_en}, 3'b011);
    check("wdt_idle", wdt_clk_en, 1'b0);
    rd(IDX_STATUS, 8'h01, 1'b0);
    @(posedge pclk);
    irq_pending <= 1'b1;
    settle(1);
    check("idle_exit", core_clk_en, 1'b1);
    @(posedge pclk);
    irq_pending <= 1'b0;
    rd(IDX_POWER_CTRL, 8'h00, 1'b0);
    apb(1'b1, IDX_WDT_CTRL, 8'ha0);
    apb(1'b1, IDX_POWER_CTRL, 8'h01);
    settle(2);
    check("wdt_idle_run", wdt_clk_en, 1'b1);
    @(posedge pclk);
    irq_pending <= 1'b1;
    @(posedge pclk);
    irq_pending <= 1'b0;
    settle(1);
    check("idle_exit2", {core_clk_en, wdt_clk_en}, 2'b11);
    // power-down entry, refused wakes, enabled wake
    en = 8'h01 << ($urandom % 8);
    apb(1'b1, IDX_WAKE_EN, en);
    apb(1'b1, IDX_POWER_CTRL, 8'h02);
    settle(2);
    check("pdown", {core_clk_en, periph_clk_en, osc_en, wdt_clk_en}, 4'h0);
    @(posedge pclk);
    irq_pending <= 1'b1;
    wake_int <= ~en;
    settle(3);
    check("pdown_hold", osc_en, 1'b0);
    @(posedge pclk);
    irq_pending <= 1'b0;
    wake_int <= en;
    settle(1);
    check("pdown_exit", {core_clk_en, osc_en}, 2'b11);
    @(posedge pclk);
    wake_int <= 8'h00;
    rd(IDX_POWER_CTRL, 8'h00, 1'b0);
    // reset pin: glitch, then a full pulse
    apb(1'b1, IDX_POWER_CTRL, 8'h10);
    apb(1'b1, IDX_STACK_PTR, 8'h3c);
    apb(1'b1, IDX_SER_BUF, 8'h5a);
    pulse(8'd3);
    seen = 1'b0;
    repeat (40) begin
      @(negedge pclk);
      if (chip_reset !== 1'b0) seen = 1'b1;
    end
    check("glitch", seen, 1'b0);
    pulse(8'd30);
    wait_rst(1'b1);
    settle(1);
    check("rst_port", {port_latch, stack_ptr}, {PORT_RESET_VAL, SP_RESET_VAL});
    wait_rst(1'b0);
    rd(IDX_POWER_CTRL, PWR_KEEP_MASK, 1'b0);
    rd(IDX_STACK_PTR, SP_RESET_VAL, 1'b0);
    rd(IDX_SER_BUF, 8'h5a, 1'b0);
    rd(IDX_AUX_CTRL, 8'h00, 1'b0);
    settle(1);
    close_out();
  end
endmodule
